// ### src/ltc_consts.svh
`ifndef LTC_CONSTS_SVH
`define LTC_CONSTS_SVH

// register byte addresses
`define LTC_OFS_CONTROL 12'h180
`define LTC_OFS_POWER 12'h184
`define LTC_OFS_HDISP 12'h188
`define LTC_OFS_VDISP 12'h18c
`define LTC_OFS_HSYNC 12'h190
`define LTC_OFS_VSYNC 12'h194
`define LTC_OFS_HINIT 12'h198
`define LTC_OFS_VINIT 12'h19c
`define LTC_OFS_STATUS 12'h200

// writable bits; everything else reads back as zero
`define LTC_MASK_CONTROL 32'h8f7f_fdff
`define LTC_MASK_POWER 32'h0000_00ff
`define LTC_MASK_HPAIR 32'h07ff_07ff
`define LTC_MASK_VPAIR 32'h03ff_03ff
`define LTC_MASK_HINIT 32'h0000_07ff
`define LTC_MASK_VINIT 32'h0000_03ff

`define LTC_RST_CONTROL 32'h0000_0000
`define LTC_RST_POWER 32'h0000_0000
`define LTC_RST_TIMING 32'h0000_0000
`define LTC_RST_INIT 32'h0000_0000

// control field positions
`define LTC_CTL_EN_BIT 0
`define LTC_CTL_HRST_BIT 1
`define LTC_CTL_VRST_BIT 2
`define LTC_CTL_WIN_BIT 3
`define LTC_CTL_DEPTH_LSB 4
`define LTC_CTL_CUR_BIT 8
`define LTC_CTL_BUF_LSB 10
`define LTC_CTL_XDEC_BIT 12
`define LTC_CTL_LINEY_BIT 13
`define LTC_CTL_HDBL_BIT 14
`define LTC_CTL_VDBL_BIT 15
`define LTC_CTL_ROOT_LSB 16
`define LTC_CTL_POLY_BIT 19
`define LTC_CTL_FD_LSB 20
`define LTC_CTL_SD_LSB 24
`define LTC_CTL_HRTFT_BIT 31

// power sequencing field positions
`define LTC_PWR_UP_LSB 0
`define LTC_PWR_FASTUP_BIT 3
`define LTC_PWR_DN_LSB 4
`define LTC_PWR_FASTDN_BIT 7

// start / end field pairs of the sync registers; total / active end in HDISP and VDISP
`define LTC_LO_LSB 0
`define LTC_HI_LSB 16

// frame counts of the interval codes 0..7
`define LTC_FRAMES_C0 7'h01
`define LTC_FRAMES_C1 7'h02
`define LTC_FRAMES_C2 7'h04
`define LTC_FRAMES_C3 7'h08
`define LTC_FRAMES_C4 7'h10
`define LTC_FRAMES_C5 7'h20
`define LTC_FRAMES_C6 7'h30
`define LTC_FRAMES_C7 7'h40

`endif

// ### src/ltc_pkg.sv
`default_nettype none
package ltc_pkg;

  typedef enum logic [5:0] {
    PWR_OFF    = 6'b000001,
    PWR_UP_SUP = 6'b000010,
    PWR_UP_CTL = 6'b000100,
    PWR_ON     = 6'b001000,
    PWR_DN_CTL = 6'b010000,
    PWR_DN_SUP = 6'b100000
  } ltc_pwr_t;

  typedef struct packed {
    logic [4:0] acc;
    logic [3:0] cnt;
    logic tick;
  } ltc_div_state_t;

  typedef struct packed {
    logic [31:0] control;
    logic [31:0] power;
    logic [31:0] hdisp;
    logic [31:0] vdisp;
    logic [31:0] hsync;
    logic [31:0] vsync;
    logic [31:0] hinit;
    logic [31:0] vinit;
    logic [31:0] rdata;
    ltc_pwr_t pwr;
    logic [6:0] wait_cnt;
    logic ge_pending;
    logic ge_alt;
    logic buf_alt;
    logic h_odd;
    logic v_odd;
    logic [1:0] sub;
    logic h_sync;
    logic v_sync;
    logic active;
    logic win_show;
    logic cur_show;
    logic pix_fetch;
    logic line_fetch;
    logic src_adv;
    logic lclk;
    logic lclk2;
    logic sup_en;
    logic ctl_en;
    logic bias_en;
    logic sig_en;
  } ltc_state_t;

endpackage
`default_nettype wire

// ### src/ltc_counter.sv
`timescale 1ns/1ps
`default_nettype none
module ltc_counter #(
  parameter int W = 11
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] init_i,
  input wire logic adv_i,
  input wire logic [W-1:0] last_i,
  output logic [W-1:0] count_o,
  output logic wrap_o
);
  import ltc_pkg::*;

  typedef struct packed {
    logic [W-1:0] count;
  } ltc_cnt_state_t;

  ltc_cnt_state_t st_reg, st_next;

  if (W < 2 || W > 16) begin : g_bad_width
    $error("ltc_counter width out of range");
  end

  always_comb begin
    st_next = st_reg;
    // >= so a total shortened under a running count still wraps
    wrap_o = adv_i && !load_i && (st_reg.count >= last_i);
    if (load_i) begin
      st_next.count = init_i;
    end else if (wrap_o) begin
      st_next.count = '0;
    end else if (adv_i) begin
      st_next.count = st_reg.count + W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.count;

endmodule
`default_nettype wire

// ### src/ltc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module ltc_clk_div (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic root_tick_i,
  input wire logic [2:0] first_code_i,
  input wire logic [3:0] second_div_i,
  output logic master_tick_o
);
  import ltc_pkg::*;

  ltc_div_state_t st_reg, st_next;
  logic [4:0] limit;
  logic [4:0] sum;
  logic stage1;

  // first stage counts in half ticks, so n.5 divisors need no second edge
  always_comb begin
    limit = {1'b0, first_code_i, 1'b1};
    if (first_code_i == 3'h0 || first_code_i == 3'h7) begin
      limit = 5'h02;
    end
    sum = st_reg.acc + 5'h02;
    stage1 = root_tick_i && (sum >= limit);
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (second_div_i == 4'h0) begin
      st_next.acc = 5'h00;
      st_next.cnt = 4'h0;
    end else begin
      if (root_tick_i) begin
        st_next.acc = stage1 ? sum - limit : sum;
      end
      if (stage1) begin
        if (st_reg.cnt + 4'h1 >= second_div_i) begin
          st_next.cnt = 4'h0;
          st_next.tick = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign master_tick_o = st_reg.tick;

  fd_one_pass_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (root_tick_i && first_code_i == 3'h0 && second_div_i == 4'h1) |=> master_tick_o)
    else $error("divide by one lost a tick");

  sd_zero_stop_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (second_div_i == 4'h0) |=> !master_tick_o)
    else $error("master tick while second divisor is zero");

endmodule
`default_nettype wire

// ### src/ltc_top.sv
`include "ltc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ltc_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic bus_clk_tick_i,
  input wire logic alt1_clk_tick_i,
  input wire logic alt2_clk_tick_i,
  input wire logic pm_force_alt_i,
  input wire logic ge_cmd_done_i,
  input wire logic ge_select_alt_i,
  output logic master_tick_o,
  output logic [10:0] h_count_o,
  output logic [9:0] v_count_o,
  output logic display_active_o,
  output logic window_show_o,
  output logic cursor_show_o,
  output logic h_sync_o,
  output logic v_sync_o,
  output logic line_clock_out_o,
  output logic secondary_line_clock_out_o,
  output logic panel_supply_enable_o,
  output logic panel_control_enable_o,
  output logic panel_bias_enable_o,
  output logic panel_signals_enable_o,
  output logic buffer_alt_o,
  output logic [2:0] color_bpp_o,
  output logic palette_bypass_o,
  output logic mono_o,
  output logic depth_reserved_o,
  output logic x_decrement_o,
  output logic line_along_y_o,
  output logic h_double_o,
  output logic v_double_o,
  output logic pixel_fetch_o,
  output logic line_fetch_o,
  output logic src_line_adv_o,
  output logic [1:0] subline_color_o
);
  import ltc_pkg::*;

  ltc_state_t st_reg, st_next;
  logic run;
  logic ctl_on;
  logic root_tick;
  logic pix_tick;
  logic h_wrap;
  logic v_wrap;
  logic [10:0] h_cnt;
  logic [9:0] v_cnt;
  logic [10:0] h_last;
  logic [9:0] v_last;
  logic h_act;
  logic v_act;
  logic disp_act;
  logic hs;
  logic vs;
  logic win_on;
  logic sub_last;
  logic [3:0] depth;
  logic [1:0] buf_sel;
  logic [6:0] up_target;
  logic [6:0] dn_target;

  function automatic logic [6:0] frames_of(input logic [2:0] code);
    case (code)
      3'h0: frames_of = `LTC_FRAMES_C0;
      3'h1: frames_of = `LTC_FRAMES_C1;
      3'h2: frames_of = `LTC_FRAMES_C2;
      3'h3: frames_of = `LTC_FRAMES_C3;
      3'h4: frames_of = `LTC_FRAMES_C4;
      3'h5: frames_of = `LTC_FRAMES_C5;
      3'h6: frames_of = `LTC_FRAMES_C6;
      default: frames_of = `LTC_FRAMES_C7;
    endcase
  endfunction

  // timing keeps running through power-down so its frame counts can finish
  assign ctl_on = st_reg.control[`LTC_CTL_EN_BIT];
  assign run = ctl_on || (st_reg.pwr != PWR_OFF);
  assign depth = st_reg.control[`LTC_CTL_DEPTH_LSB +: 4];
  assign buf_sel = st_reg.control[`LTC_CTL_BUF_LSB +: 2];

  always_comb begin
    case (st_reg.control[`LTC_CTL_ROOT_LSB +: 2])
      2'b00: root_tick = bus_clk_tick_i;
      2'b01: root_tick = alt1_clk_tick_i;
      default: root_tick = alt2_clk_tick_i;
    endcase
  end

  ltc_clk_div u_div (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .root_tick_i(root_tick),
    .first_code_i(st_reg.control[`LTC_CTL_FD_LSB +: 3]),
    .second_div_i(run ? st_reg.control[`LTC_CTL_SD_LSB +: 4] : 4'h0),
    .master_tick_o(pix_tick)
  );

  // counts run 0..total+1 horizontally and 0..total vertically
  assign h_last = st_reg.hdisp[`LTC_LO_LSB +: 11] + 11'h001;
  assign v_last = st_reg.vdisp[`LTC_LO_LSB +: 10];

  ltc_counter #(.W(11)) u_hcnt (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(!run || st_reg.control[`LTC_CTL_HRST_BIT]),
    .init_i(run ? st_reg.hinit[10:0] : 11'h000),
    .adv_i(pix_tick),
    .last_i(h_last),
    .count_o(h_cnt),
    .wrap_o(h_wrap)
  );

  ltc_counter #(.W(10)) u_vcnt (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(!run || st_reg.control[`LTC_CTL_VRST_BIT]),
    .init_i(run ? st_reg.vinit[9:0] : 10'h000),
    .adv_i(h_wrap),
    .last_i(v_last),
    .count_o(v_cnt),
    .wrap_o(v_wrap)
  );

  assign h_act = h_cnt < st_reg.hdisp[`LTC_HI_LSB +: 11];
  assign v_act = v_cnt <= st_reg.vdisp[`LTC_HI_LSB +: 10];
  assign disp_act = h_act && v_act;
  assign hs = (h_cnt >= st_reg.hsync[`LTC_LO_LSB +: 11])
    && (h_cnt < st_reg.hsync[`LTC_HI_LSB +: 11]);
  assign vs = (v_cnt >= st_reg.vsync[`LTC_LO_LSB +: 10])
    && (v_cnt < st_reg.vsync[`LTC_HI_LSB +: 10]);
  assign win_on = ctl_on && st_reg.control[`LTC_CTL_WIN_BIT];
  assign sub_last = !st_reg.control[`LTC_CTL_POLY_BIT] || (st_reg.sub == 2'h2);
  assign up_target = frames_of(st_reg.power[`LTC_PWR_UP_LSB +: 3]) + 7'h01;
  assign dn_target = frames_of(st_reg.power[`LTC_PWR_DN_LSB +: 3]) + 7'h01;

  always_comb begin
    st_next = st_reg;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LTC_OFS_CONTROL: st_next.control = reg_wdata_i & `LTC_MASK_CONTROL;
        `LTC_OFS_POWER: st_next.power = reg_wdata_i & `LTC_MASK_POWER;
        `LTC_OFS_HDISP: st_next.hdisp = reg_wdata_i & `LTC_MASK_HPAIR;
        `LTC_OFS_VDISP: st_next.vdisp = reg_wdata_i & `LTC_MASK_VPAIR;
        `LTC_OFS_HSYNC: st_next.hsync = reg_wdata_i & `LTC_MASK_HPAIR;
        `LTC_OFS_VSYNC: st_next.vsync = reg_wdata_i & `LTC_MASK_VPAIR;
        `LTC_OFS_HINIT: st_next.hinit = reg_wdata_i & `LTC_MASK_HINIT;
        `LTC_OFS_VINIT: st_next.vinit = reg_wdata_i & `LTC_MASK_VINIT;
        default: ;
      endcase
    end
    st_next.rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LTC_OFS_CONTROL: st_next.rdata = st_reg.control;
        `LTC_OFS_POWER: st_next.rdata = st_reg.power;
        `LTC_OFS_HDISP: st_next.rdata = st_reg.hdisp;
        `LTC_OFS_VDISP: st_next.rdata = st_reg.vdisp;
        `LTC_OFS_HSYNC: st_next.rdata = st_reg.hsync;
        `LTC_OFS_VSYNC: st_next.rdata = st_reg.vsync;
        `LTC_OFS_HINIT: st_next.rdata = st_reg.hinit;
        `LTC_OFS_VINIT: st_next.rdata = st_reg.vinit;
        `LTC_OFS_STATUS: st_next.rdata = {st_reg.pwr, v_cnt, 5'h00, h_cnt};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // panel power sequencing, intervals counted in frame wraps
    if (v_wrap && st_reg.wait_cnt != 7'h7f) begin
      st_next.wait_cnt = st_reg.wait_cnt + 7'h01;
    end
    case (st_reg.pwr)
      PWR_OFF: begin
        if (ctl_on) begin
          st_next.pwr = st_reg.power[`LTC_PWR_FASTUP_BIT] ? PWR_ON : PWR_UP_SUP;
          st_next.wait_cnt = 7'h00;
        end
      end
      PWR_UP_SUP: begin
        if (!ctl_on) begin
          st_next.pwr = PWR_DN_SUP;
          st_next.wait_cnt = 7'h00;
        end else if (st_reg.wait_cnt >= up_target) begin
          st_next.pwr = PWR_UP_CTL;
          st_next.wait_cnt = 7'h00;
        end
      end
      PWR_UP_CTL: begin
        if (!ctl_on) begin
          st_next.pwr = PWR_DN_CTL;
          st_next.wait_cnt = 7'h00;
        end else if (st_reg.wait_cnt >= up_target) begin
          st_next.pwr = PWR_ON;
        end
      end
      PWR_ON: begin
        if (!ctl_on) begin
          st_next.pwr = PWR_DN_CTL;
          st_next.wait_cnt = 7'h00;
        end
      end
      PWR_DN_CTL: begin
        if (st_reg.wait_cnt >= dn_target) begin
          st_next.pwr = PWR_DN_SUP;
          st_next.wait_cnt = 7'h00;
        end
      end
      PWR_DN_SUP: begin
        if (st_reg.wait_cnt >= dn_target) begin
          st_next.pwr = PWR_OFF;
        end
      end
      default: st_next.pwr = PWR_OFF;
    endcase
    if (!ctl_on && st_reg.power[`LTC_PWR_FASTDN_BIT]) begin
      st_next.pwr = PWR_OFF;
    end
    st_next.sup_en = st_next.pwr != PWR_OFF;
    st_next.ctl_en = (st_next.pwr == PWR_UP_CTL) || (st_next.pwr == PWR_ON)
      || (st_next.pwr == PWR_DN_CTL);
    st_next.sig_en = st_next.ctl_en;
    st_next.bias_en = st_next.pwr == PWR_ON;

    // engine request takes effect at the next frame start only
    if (ge_cmd_done_i) begin
      st_next.ge_pending = ge_select_alt_i;
    end
    if (v_wrap) begin
      st_next.ge_alt = ge_cmd_done_i ? ge_select_alt_i : st_reg.ge_pending;
    end
    st_next.buf_alt = win_on && (pm_force_alt_i || buf_sel == 2'b10
      || (buf_sel == 2'b01 && st_reg.ge_alt));

    st_next.active = st_reg.sig_en && disp_act;
    st_next.win_show = st_reg.sig_en && win_on && disp_act;
    st_next.cur_show = st_reg.sig_en && ctl_on && st_reg.control[`LTC_CTL_CUR_BIT]
      && disp_act;
    st_next.h_sync = st_reg.sig_en && hs;
    st_next.v_sync = st_reg.sig_en && vs;
    st_next.lclk = st_reg.sig_en
      && (st_reg.control[`LTC_CTL_HRTFT_BIT] ? v_act : hs);
    st_next.lclk2 = st_reg.sig_en
      && (st_reg.control[`LTC_CTL_HRTFT_BIT] ? vs : hs);

    // horizontal doubling fetches every second active pixel
    st_next.pix_fetch = pix_tick && st_reg.win_show && disp_act && win_on
      && (!st_reg.control[`LTC_CTL_HDBL_BIT] || !st_reg.h_odd);
    if (pix_tick) begin
      if (h_wrap) begin
        st_next.h_odd = 1'b0;
      end else if (disp_act) begin
        st_next.h_odd = !st_reg.h_odd;
      end
    end

    st_next.line_fetch = h_wrap && win_on;
    st_next.src_adv = 1'b0;
    if (h_wrap) begin
      if (v_wrap) begin
        st_next.sub = 2'h0;
        st_next.v_odd = 1'b0;
        st_next.src_adv = 1'b1;
      end else begin
        st_next.sub = sub_last ? 2'h0 : st_reg.sub + 2'h1;
        if (sub_last) begin
          if (st_reg.control[`LTC_CTL_VDBL_BIT]) begin
            st_next.v_odd = !st_reg.v_odd;
            st_next.src_adv = st_reg.v_odd;
          end else begin
            st_next.v_odd = 1'b0;
            st_next.src_adv = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
      st_reg.control <= `LTC_RST_CONTROL;
      st_reg.power <= `LTC_RST_POWER;
      st_reg.hdisp <= `LTC_RST_TIMING;
      st_reg.vdisp <= `LTC_RST_TIMING;
      st_reg.hsync <= `LTC_RST_TIMING;
      st_reg.vsync <= `LTC_RST_TIMING;
      st_reg.hinit <= `LTC_RST_INIT;
      st_reg.vinit <= `LTC_RST_INIT;
      st_reg.pwr <= PWR_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;
  assign master_tick_o = pix_tick;
  assign h_count_o = h_cnt;
  assign v_count_o = v_cnt;
  assign display_active_o = st_reg.active;
  assign window_show_o = st_reg.win_show;
  assign cursor_show_o = st_reg.cur_show;
  assign h_sync_o = st_reg.h_sync;
  assign v_sync_o = st_reg.v_sync;
  assign line_clock_out_o = st_reg.lclk;
  assign secondary_line_clock_out_o = st_reg.lclk2;
  assign panel_supply_enable_o = st_reg.sup_en;
  assign panel_control_enable_o = st_reg.ctl_en;
  assign panel_bias_enable_o = st_reg.bias_en;
  assign panel_signals_enable_o = st_reg.sig_en;
  assign buffer_alt_o = st_reg.buf_alt;
  // reserved depth codes still report a width; depth_reserved_o flags them
  assign color_bpp_o = (depth == 4'hc) ? 3'h4 : {1'b0, depth[1:0]};
  assign palette_bypass_o = depth[3];
  assign mono_o = depth[3] && !depth[2];
  assign depth_reserved_o = depth[2] && (!depth[3] || (depth[1:0] != 2'b00));
  assign x_decrement_o = st_reg.control[`LTC_CTL_XDEC_BIT];
  assign line_along_y_o = st_reg.control[`LTC_CTL_LINEY_BIT];
  assign h_double_o = st_reg.control[`LTC_CTL_HDBL_BIT];
  assign v_double_o = st_reg.control[`LTC_CTL_VDBL_BIT];
  assign pixel_fetch_o = st_reg.pix_fetch;
  assign line_fetch_o = st_reg.line_fetch;
  assign src_line_adv_o = st_reg.src_adv;
  assign subline_color_o = st_reg.sub;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence sup_only_s;
    panel_supply_enable_o && !panel_control_enable_o && !panel_bias_enable_o;
  endsequence

  sequence bias_off_s;
    panel_supply_enable_o && panel_control_enable_o && !panel_bias_enable_o;
  endsequence

  rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside the read answer cycle");
  h_init_load_a: assert property ((st_reg.control[1] && run) |=>
    h_count_o == $past(st_reg.hinit[10:0]))
    else $error("horizontal counter not held at initial value");
  v_init_load_a: assert property ((st_reg.control[2] && run) |=>
    v_count_o == $past(st_reg.vinit[9:0]))
    else $error("vertical counter not held at initial value");
  h_line_wrap_a: assert property ((pix_tick && run && !st_reg.control[1]
    && h_cnt == h_last) |=> h_count_o == 11'h000)
    else $error("horizontal counter missed its wrap");
  v_frame_wrap_a: assert property ((h_wrap && !st_reg.control[2]
    && v_cnt == v_last) |=> v_count_o == 10'h000)
    else $error("vertical counter missed its wrap");
  h_sync_start_a: assert property ((st_reg.sig_en && h_cnt == st_reg.hsync[10:0]
    && st_reg.hsync[26:16] > st_reg.hsync[10:0]) |=> h_sync_o)
    else $error("horizontal sync absent at start position");
  win_gate_a: assert property (window_show_o |-> $past(st_reg.control[3]
    && st_reg.control[0]))
    else $error("window shown while disabled");
  cursor_gate_a: assert property (cursor_show_o |-> $past(st_reg.control[8]))
    else $error("cursor shown while disabled");
  pm_force_alt_a: assert property ((win_on && pm_force_alt_i) |=> buffer_alt_o)
    else $error("power management force ignored");
  fast_up_a: assert property ((st_reg.pwr == PWR_OFF && ctl_on && st_reg.power[3])
    |=> panel_supply_enable_o && panel_control_enable_o && panel_bias_enable_o
    && panel_signals_enable_o)
    else $error("fast power-up did not enable all at once");
  fast_down_a: assert property ((!ctl_on && st_reg.power[7]) |=>
    !panel_supply_enable_o && !panel_signals_enable_o)
    else $error("fast power-down left an enable on");
  up_sequence_a: assert property (($rose(panel_supply_enable_o)
    && !panel_control_enable_o) |-> sup_only_s [*2])
    else $error("power-up step came too early");
  down_sequence_a: assert property (($fell(panel_bias_enable_o)
    && panel_control_enable_o && !st_reg.power[7]) |-> bias_off_s [*2])
    else $error("power-down step came too early");

endmodule
`default_nettype wire

// ### testbench/ltc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ltc_far_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  output logic bus_tick_o,
  output logic alt1_tick_o,
  output logic alt2_tick_o
);
  logic [1:0] ph_reg;
  logic half_reg;
  // distinct rates so the root select shows in the tick count
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || ph_reg == 2'h2) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
    end
    half_reg <= sys_rst_i ? 1'b0 : ~half_reg;
  end
  assign bus_tick_o = 1'b1;
  assign alt1_tick_o = half_reg;
  assign alt2_tick_o = ph_reg == 2'h2;
endmodule
`default_nettype wire

// ### testbench/lcd_timing_and_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_timing_and_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h0;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic t0, t1, t2, mt, byp, mono, rsv, xd, hd;
  logic ba, hs, da, ws, cs, lc, lc2, lf, ly, vdb;
  logic pm = 1'b0;
  logic ged = 1'b0;
  logic ges = 1'b0;
  logic [31:0] rdata;
  logic [10:0] hc;
  logic [9:0] vc;
  logic [3:0] pen;
  logic [2:0] bpp;
  logic [3:0] dc [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hb, 4'hc};
  logic [5:0] de [7] = '{6'h00, 6'h08, 6'h10, 6'h18, 6'h06, 6'h1e, 6'h24};
  logic [31:0] cw [8] = '{32'h0100_0001, 32'h0300_0001, 32'h0101_0001, 32'h0102_0001,
    32'h0103_0001, 32'h0110_0001, 32'h0120_0001, 32'h0000_0001};
  int ex [8] = '{60, 20, 30, 20, 20, 40, 24, 0};
  int n_errors = 0;
  int total_checks = 0;
  int n, m, w, q, r;
  always #20 clk = ~clk;
  ltc_far_model far_u (.core_clk_i(clk), .sys_rst_i(rst), .bus_tick_o(t0),
    .alt1_tick_o(t1), .alt2_tick_o(t2));
  ltc_top dut_u (.core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_clk_tick_i(t0),
    .alt1_clk_tick_i(t1), .alt2_clk_tick_i(t2), .pm_force_alt_i(pm),
    .ge_cmd_done_i(ged), .ge_select_alt_i(ges), .master_tick_o(mt), .h_count_o(hc),
    .v_count_o(vc), .display_active_o(da), .window_show_o(ws), .cursor_show_o(cs),
    .h_sync_o(hs), .v_sync_o(), .line_clock_out_o(lc), .secondary_line_clock_out_o(lc2),
    .panel_supply_enable_o(pen[3]), .panel_control_enable_o(pen[2]),
    .panel_bias_enable_o(pen[1]), .panel_signals_enable_o(pen[0]), .buffer_alt_o(ba),
    .color_bpp_o(bpp), .palette_bypass_o(byp), .mono_o(mono), .depth_reserved_o(rsv),
    .x_decrement_o(xd), .line_along_y_o(ly), .h_double_o(hd), .v_double_o(vdb),
    .pixel_fetch_o(), .line_fetch_o(lf), .src_line_adv_o(), .subline_color_o());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // panel enables at three points of a slow sequence, one nibble per point
  task automatic pwr_walk(input logic [31:0] c, input logic [11:0] e);
    wr_reg(12'h180, c);
    step(20);
    chk(pen, e[11:8]);
    step(60);
    chk(pen, e[7:4]);
    step(60);
    chk(pen, e[3:0]);
  endtask
  // one full 32-pixel line of h_sync, active, window, cursor, line clock and line fetch outputs
  task automatic line_count();
    n = 0;
    m = 0;
    w = 0;
    q = 0;
    r = 0;
    repeat (32) begin
      step(1);
      n += hs;
      m += da;
      w += ws + cs;
      q += lc + lc2;
      r += lf;
    end
  endtask
  // steps until the horizontal counter is back at zero, cycles in n
  task automatic wait_h0();
    n = 0;
    do begin
      step(1);
      n++;
    end while (hc !== 11'h0 && n < 500);
    if (n >= 500) begin
      n_errors++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h180, 32'h0);
    rd_chk(12'h184, 32'h0);
    // enable left clear so power sequencing stays idle
    wr_reg(12'h180, 32'hffff_fffe);
    rd_chk(12'h180, 32'h8f7f_fdfe);
    chk({xd, hd, rsv, ly, vdb}, 32'h1f);
    rd_chk(12'h1a0, 32'h0);
    foreach (dc[i]) begin
      wr_reg(12'h180, {24'h0, dc[i], 4'h0});
      chk({bpp, byp, mono, rsv}, de[i]);
    end
    wr_reg(12'h184, 32'h88);
    wr_reg(12'h198, 32'h123);
    wr_reg(12'h19c, 32'h2a5);
    wr_reg(12'h180, 32'h0100_0007);
    step(2);
    chk(pen, 32'hf);
    chk({hc, vc}, {11'h123, 10'h2a5});
    foreach (cw[i]) begin
      wr_reg(12'h180, cw[i]);
      step(3);
      n = 0;
      repeat (60) begin
        step(1);
        if (mt === 1'b1)
          n++;
      end
      chk(n, ex[i]);
    end
    wr_reg(12'h188, 32'h0008_001e);
    wr_reg(12'h190, 32'h0014_0010);
    wr_reg(12'h194, 32'h0002_0001);
    wr_reg(12'h180, 32'h0100_0001);
    wait_h0();
    wait_h0();
    chk(n, 32);
    wr_reg(12'h180, 32'h0100_0809);
    step(1);
    chk(ba, 32'h1);
    wr_reg(12'h180, 32'h0100_0509);
    step(1);
    chk(ba, 32'h0);
    @(posedge clk);
    pm <= 1'b1;
    step(2);
    chk(ba, 32'h1);
    @(posedge clk);
    pm <= 1'b0;
    ged <= 1'b1;
    ges <= 1'b1;
    @(posedge clk);
    ged <= 1'b0;
    wait_h0();
    wait_h0();
    chk(ba, 32'h1);
    line_count();
    chk(n, 4);
    chk(m, 8);
    chk(w, 16);
    chk(q, 8);
    chk(r, 1);
    wr_reg(12'h180, 32'h8100_0001);
    line_count();
    chk(n, 4);
    chk(w, 0);
    chk(q, 32);
    chk(r, 0);
    wr_reg(12'h184, 32'h0);
    pwr_walk(32'h0100_0000, 12'hd80);
    pwr_walk(32'h0100_0001, 12'h8df);
    wr_reg(12'h184, 32'h88);
    wr_reg(12'h180, 32'h0);
    step(2);
    chk(pen, 32'h0);
    chk(hc, 32'h0);
    rd_chk(12'h200, 32'h0400_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
